// [dim_consts.svh]
// constants for the digital if modulator: widths, offsets, field positions, coefficients
// assumes it is included by the package and by every design module
`ifndef DIM_CONSTS_SVH
`define DIM_CONSTS_SVH

// ==================================================
// data widths
`define DIM_DW 16
`define DIM_CW 10
`define DIM_PW 26
`define DIM_MW 18
`define DIM_HW 20
`define DIM_WW 21
`define DIM_ACCW 32
`define DIM_OUT_MAX 16'sh7fff
`define DIM_OUT_MIN 16'sh8000

// ==================================================
// carrier: eighth-cycle phase steps, q8 amplitudes
`define DIM_PHASES 16
`define DIM_LO_ONE (10'sh100)
`define DIM_LO_RT2 (10'sh0b5)
`define DIM_LEAD 3'h2
`define DIM_COEF_SHIFT 8

// ==================================================
// hilbert fir: magnitudes of taps moving outward from the centre
`define DIM_TAPS 19
`define DIM_HILB_DELAY 9
`define DIM_HILB_SHIFT 9
`define DIM_HC0 10'sh13e
`define DIM_HC1 10'sh05b
`define DIM_HC2 10'sh028
`define DIM_HC3 10'sh011
`define DIM_HC4 10'sh006
`define DIM_LATENCY 12

// ==================================================
// register map and control fields
`define DIM_AW 4
`define DIM_REG_CTRL 4'h0
`define DIM_REG_STATUS 4'h4
`define DIM_CTRL_W 6
`define DIM_CTRL_RESET 6'h00
`define DIM_F_DUAL 0
`define DIM_F_CHSEL 1
`define DIM_F_RATE_LO 2
`define DIM_F_RATE_HI 3
`define DIM_F_HILB 4
`define DIM_F_SIDEBAND 5
`define DIM_RATE_NONE 2'h0
`define DIM_RATE_HALF 2'h1
`define DIM_RATE_QUARTER 2'h2
`define DIM_RATE_EIGHTH 2'h3

`endif

// [dim_pkg.sv]
// types and shared arithmetic of the digital if modulator
// assumes dim_consts.svh is on the include path
`include "dim_consts.svh"

package dim_pkg;

  typedef logic signed [`DIM_DW-1:0] dim_sample_t;
  typedef logic signed [`DIM_CW-1:0] dim_coef_t;
  typedef logic signed [`DIM_PW-1:0] dim_prod_t;
  typedef logic signed [`DIM_MW-1:0] dim_mix_t;
  typedef logic signed [`DIM_HW-1:0] dim_hilb_t;
  typedef logic signed [`DIM_WW-1:0] dim_wide_t;

  typedef enum logic [3:0] {
    rate_none = 4'b0001,
    rate_half = 4'b0010,
    rate_quarter = 4'b0100,
    rate_eighth = 4'b1000
  } dim_rate_t;

  function automatic dim_prod_t dim_mul(input dim_sample_t s, input dim_coef_t c);
    dim_prod_t se;
    dim_prod_t ce;
    se = dim_prod_t'(s);
    ce = dim_prod_t'(c);
    return se * ce;
  endfunction : dim_mul

  function automatic dim_sample_t dim_sat(input dim_wide_t v);
    if (v > dim_wide_t'(`DIM_OUT_MAX)) begin
      return `DIM_OUT_MAX;
    end else if (v < dim_wide_t'(`DIM_OUT_MIN)) begin
      return `DIM_OUT_MIN;
    end
    return v[`DIM_DW-1:0];
  endfunction : dim_sat

endpackage : dim_pkg

// [dim_path_if.sv]
// carrier between modulator core, carrier generator and hilbert fir
// assumes all three modules share one clock
`timescale 1ns/1ps

interface dim_path_if;
  import dim_pkg::*;
  logic [3:0] phase;
  dim_rate_t rate;
  dim_coef_t lo_cos;
  dim_coef_t lo_sin;
  dim_coef_t hlo_cos;
  dim_coef_t hlo_sin;
  dim_mix_t hilb_in;
  dim_hilb_t hilb_out;

  modport lo_src(input rate, output phase, output lo_cos, output lo_sin,
                 output hlo_cos, output hlo_sin);
  modport fir(input hilb_in, output hilb_out);
  modport core(output rate, output hilb_in, input phase, input lo_cos, input lo_sin,
               input hlo_cos, input hlo_sin, input hilb_out);
endinterface : dim_path_if

// [dim_lo_gen.sv]
// sixteen-state phase sequencer and carrier tables for main and hilbert paths
// assumes rate is a registered one-hot code from the core
`timescale 1ns/1ps
`include "dim_consts.svh"

module dim_lo_gen
  import dim_pkg::*;
(
  input logic core_clk,
  input logic nrst,
  dim_path_if.lo_src lo
);
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic [2:0] ep;

  function automatic dim_coef_t cos8(input logic [2:0] p);
    case (p)
      3'h0: cos8 = `DIM_LO_ONE;
      3'h1, 3'h7: cos8 = `DIM_LO_RT2;
      3'h2, 3'h6: cos8 = '0;
      3'h3, 3'h5: cos8 = -`DIM_LO_RT2;
      default: cos8 = -`DIM_LO_ONE;
    endcase
  endfunction : cos8

  // ==================================================
  // sequencer
  always_comb begin
    next_phase = phase + 4'h1;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

  // ==================================================
  // carriers; no modulation parks ep at zero while phase keeps counting, so cos is unity
  always_comb begin
    case (lo.rate)
      rate_half: ep = {phase[0], 2'b00};
      rate_quarter: ep = {phase[1:0], 1'b0};
      rate_eighth: ep = phase[2:0];
      default: ep = 3'h0;
    endcase
    lo.lo_cos = cos8(ep);
    lo.lo_sin = cos8(ep - `DIM_LEAD);
    lo.hlo_cos = cos8(ep + `DIM_LEAD);
    lo.hlo_sin = cos8(ep);
  end

  assign lo.phase = phase;

  // the edge that ends reset still clears phase, so no step is owed after it
  property p_phase_step;
    @(posedge core_clk) disable iff (!nrst) nrst |=> (phase == $past(phase) + 4'h1);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not step by one");

  property p_lo_lead;
    @(posedge core_clk) disable iff (!nrst)
      (lo.hlo_cos == -lo.lo_sin) && (lo.hlo_sin == lo.lo_cos);
  endproperty
  a_lo_lead: assert property (p_lo_lead) else $error("hilbert carrier not leading");

  property p_rate_half;
    @(posedge core_clk) disable iff (!nrst)
      (lo.rate == rate_half) && ($past(lo.rate) == rate_half) |-> (lo.lo_cos == -$past(lo.lo_cos));
  endproperty
  a_rate_half: assert property (p_rate_half) else $error("half rate carrier wrong");

  property p_rate_eighth;
    @(posedge core_clk) disable iff (!nrst)
      (lo.rate == rate_eighth) && ($past(lo.rate, 4) == rate_eighth)
      |-> (lo.lo_cos == -$past(lo.lo_cos, 4));
  endproperty
  a_rate_eighth: assert property (p_rate_eighth) else $error("eighth rate carrier wrong");

endmodule : dim_lo_gen

// [dim_hilbert_fir.sv]
// antisymmetric hilbert fir; centre tap sits nine samples behind the input
// assumes the input is the registered hilbert-path product, one sample a clock
`timescale 1ns/1ps
`include "dim_consts.svh"

module dim_hilbert_fir
  import dim_pkg::*;
#(
  parameter int TAPS = `DIM_TAPS
)(
  input logic core_clk,
  input logic nrst,
  dim_path_if.fir hp
);
  localparam int CTR = TAPS / 2;
  localparam int PAIRS = (TAPS + 1) / 4;
  localparam int AW = `DIM_ACCW;

  dim_mix_t line [1:TAPS-1];
  dim_mix_t next_line [1:TAPS-1];
  logic [4:0] flat_cnt;
  logic [4:0] next_flat_cnt;

  function automatic dim_coef_t hcoef(input int m);
    case (m)
      0: hcoef = `DIM_HC0;
      1: hcoef = `DIM_HC1;
      2: hcoef = `DIM_HC2;
      3: hcoef = `DIM_HC3;
      default: hcoef = `DIM_HC4;
    endcase
  endfunction : hcoef

  function automatic dim_mix_t tap(input int k);
    if (k == 0) begin
      return hp.hilb_in;
    end
    return line[k];
  endfunction : tap

  always_comb begin
    next_line[1] = hp.hilb_in;
    for (int k = 2; k < TAPS; k++) begin
      next_line[k] = line[k-1];
    end
    if (hp.hilb_in != line[1]) begin
      next_flat_cnt = 5'h00;
    end else if (flat_cnt == 5'h1f) begin
      next_flat_cnt = flat_cnt;
    end else begin
      next_flat_cnt = flat_cnt + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int k = 1; k < TAPS; k++) begin
        line[k] <= '0;
      end
      flat_cnt <= '0;
    end else begin
      line <= next_line;
      flat_cnt <= next_flat_cnt;
    end
  end

  // even taps are zero, so only the odd-offset pairs are summed
  always_comb begin
    logic signed [`DIM_ACCW-1:0] acc;
    logic signed [`DIM_ACCW-1:0] diff;
    logic signed [`DIM_ACCW-1:0] cw;
    acc = '0;
    diff = '0;
    cw = '0;
    for (int m = 0; m < PAIRS; m++) begin
      diff = AW'(tap(CTR + 1 + 2 * m));
      diff = diff - AW'(tap(CTR - 1 - 2 * m));
      cw = AW'(hcoef(m));
      acc = acc + diff * cw;
    end
    hp.hilb_out = acc[`DIM_HILB_SHIFT+`DIM_HW-1:`DIM_HILB_SHIFT];
  end

  property p_dc_null;
    @(posedge core_clk) disable iff (!nrst)
      (flat_cnt >= 5'h11) && (hp.hilb_in == line[1]) |-> (hp.hilb_out == '0);
  endproperty
  a_dc_null: assert property (p_dc_null) else $error("hilbert fir passes dc");

endmodule : dim_hilbert_fir

// [dim_if_modulator.sv]
// top of the digital if modulator: avalon register slave, channel select,
// real or complex mixing, nine-sample main delay and hilbert image rejection
// assumes interpolated i/q samples arrive every core_clk (the dac update clock)
`timescale 1ns/1ps
`include "dim_consts.svh"

module dim_if_modulator
  import dim_pkg::*;
(
  input logic core_clk,
  input logic nrst,
  input logic [`DIM_AW-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input dim_sample_t in_i,
  input dim_sample_t in_q,
  output dim_sample_t dac_data
);

  // ==================================================
  // register slave
  logic [`DIM_CTRL_W-1:0] ctrl;
  logic [`DIM_CTRL_W-1:0] next_ctrl;
  logic wait_q;
  logic next_wait;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [3:0] cfg_age;
  logic [3:0] next_cfg_age;

  logic dual;
  logic chsel;
  logic hilb_active;
  logic sideband;
  logic [1:0] rate_code;

  assign dual = ctrl[`DIM_F_DUAL];
  assign chsel = ctrl[`DIM_F_CHSEL];
  assign sideband = ctrl[`DIM_F_SIDEBAND];
  assign rate_code = {ctrl[`DIM_F_RATE_HI], ctrl[`DIM_F_RATE_LO]};
  // hilbert path only means something for a complex pair
  assign hilb_active = dual && ctrl[`DIM_F_HILB];

  dim_path_if path();

  always_comb begin
    next_ctrl = ctrl;
    next_rdata = rdata;
    next_wait = 1'b1;
    if (wait_q && (avs_read || avs_write)) begin
      next_wait = 1'b0;
    end
    if (wait_q && avs_read) begin
      case (avs_address)
        `DIM_REG_CTRL: next_rdata = {{(32-`DIM_CTRL_W){1'b0}}, ctrl};
        `DIM_REG_STATUS: next_rdata = {23'h000000, hilb_active, path.rate, path.phase};
        default: next_rdata = 32'h00000000;
      endcase
    end
    if (!wait_q && avs_write && (avs_address == `DIM_REG_CTRL)) begin
      next_ctrl = avs_writedata[`DIM_CTRL_W-1:0];
    end
    if (next_ctrl != ctrl) begin
      next_cfg_age = 4'h0;
    end else if (cfg_age == 4'hf) begin
      next_cfg_age = cfg_age;
    end else begin
      next_cfg_age = cfg_age + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl <= `DIM_CTRL_RESET;
      wait_q <= 1'b1;
      rdata <= 32'h00000000;
      cfg_age <= 4'h0;
    end else begin
      ctrl <= next_ctrl;
      wait_q <= next_wait;
      rdata <= next_rdata;
      cfg_age <= next_cfg_age;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata;

  // ==================================================
  // carrier rate mode
  dim_rate_t rate;
  dim_rate_t next_rate;

  always_comb begin
    case (rate_code)
      `DIM_RATE_HALF: next_rate = rate_half;
      `DIM_RATE_QUARTER: next_rate = rate_quarter;
      `DIM_RATE_EIGHTH: next_rate = rate_eighth;
      default: next_rate = rate_none;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rate <= rate_none;
    end else begin
      rate <= next_rate;
    end
  end

  assign path.rate = rate;

  dim_lo_gen u_lo (
    .core_clk(core_clk),
    .nrst(nrst),
    .lo(path)
  );

  // ==================================================
  // mixing stage
  function automatic dim_mix_t mix(input dim_sample_t a, input dim_sample_t b,
                                   input dim_coef_t c, input dim_coef_t s, input logic imag);
    dim_prod_t p;
    if (imag) begin
      p = dim_mul(a, s) + dim_mul(b, c);
    end else begin
      p = dim_mul(a, c) - dim_mul(b, s);
    end
    return dim_mix_t'(p >>> `DIM_COEF_SHIFT);
  endfunction : mix

  dim_sample_t in_i_q;
  dim_sample_t in_q_q;
  dim_sample_t pick;
  dim_mix_t main_prod;
  dim_mix_t hilb_prod;
  dim_mix_t next_main_prod;
  dim_mix_t next_hilb_prod;

  always_comb begin
    pick = chsel ? in_q_q : in_i_q;
    if (dual) begin
      next_main_prod = mix(in_i_q, in_q_q, path.lo_cos, path.lo_sin, chsel);
      next_hilb_prod = mix(in_i_q, in_q_q, path.hlo_cos, path.hlo_sin, chsel);
    end else begin
      next_main_prod = mix(pick, '0, path.lo_cos, path.lo_sin, 1'b0);
      next_hilb_prod = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      in_i_q <= '0;
      in_q_q <= '0;
      main_prod <= '0;
      hilb_prod <= '0;
    end else begin
      in_i_q <= in_i;
      in_q_q <= in_q;
      main_prod <= next_main_prod;
      hilb_prod <= next_hilb_prod;
    end
  end

  // ==================================================
  // main delay and hilbert path
  // main path is always delayed so latency does not jump when hilbert toggles
  dim_mix_t dly [1:`DIM_HILB_DELAY];
  dim_mix_t next_dly [1:`DIM_HILB_DELAY];

  always_comb begin
    next_dly[1] = main_prod;
    for (int k = 2; k <= `DIM_HILB_DELAY; k++) begin
      next_dly[k] = dly[k-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int k = 1; k <= `DIM_HILB_DELAY; k++) begin
        dly[k] <= '0;
      end
    end else begin
      dly <= next_dly;
    end
  end

  assign path.hilb_in = hilb_prod;

  dim_hilbert_fir #(
    .TAPS(`DIM_TAPS)
  ) u_fir (
    .core_clk(core_clk),
    .nrst(nrst),
    .hp(path)
  );

  // ==================================================
  // summation and output register
  dim_wide_t main_w;
  dim_wide_t hilb_w;
  dim_wide_t sum_w;
  dim_sample_t next_dac;

  assign main_w = dim_wide_t'(dly[`DIM_HILB_DELAY]);
  assign hilb_w = dim_wide_t'(path.hilb_out);

  always_comb begin
    if (!hilb_active) begin
      sum_w = main_w;
    end else if (sideband) begin
      sum_w = main_w - hilb_w;
    end else begin
      sum_w = main_w + hilb_w;
    end
    // saturate rather than wrap: a wrapped sample is a full-scale glitch at the dac
    next_dac = dim_sat(sum_w);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dac_data <= '0;
    end else begin
      dac_data <= next_dac;
    end
  end

  // ==================================================
  // checks
  sequence s_settled;
    cfg_age == 4'hf;
  endsequence

  property p_single_i;
    @(posedge core_clk) disable iff (!nrst)
      s_settled ##0 (!dual && !chsel && rate_code == `DIM_RATE_NONE)
      |-> (dac_data == $past(in_i, `DIM_LATENCY));
  endproperty
  a_single_i: assert property (p_single_i) else $error("single mode i not passed");

  property p_single_q;
    @(posedge core_clk) disable iff (!nrst)
      s_settled ##0 (!dual && chsel && rate_code == `DIM_RATE_NONE)
      |-> (dac_data == $past(in_q, `DIM_LATENCY));
  endproperty
  a_single_q: assert property (p_single_q) else $error("single mode q not passed");

  property p_single_mix;
    @(posedge core_clk) disable iff (!nrst)
      !dual |=> (main_prod ==
        dim_mix_t'(dim_mul($past(pick), $past(path.lo_cos)) >>> `DIM_COEF_SHIFT));
  endproperty
  a_single_mix: assert property (p_single_mix) else $error("real mixing product wrong");

  property p_dual_real;
    @(posedge core_clk) disable iff (!nrst)
      dual && !chsel |=> (main_prod == dim_mix_t'((dim_mul($past(in_i_q), $past(path.lo_cos))
        - dim_mul($past(in_q_q), $past(path.lo_sin))) >>> `DIM_COEF_SHIFT));
  endproperty
  a_dual_real: assert property (p_dual_real) else $error("complex real product wrong");

  property p_dual_imag;
    @(posedge core_clk) disable iff (!nrst)
      dual && chsel |=> (main_prod == dim_mix_t'((dim_mul($past(in_i_q), $past(path.lo_sin))
        + dim_mul($past(in_q_q), $past(path.lo_cos))) >>> `DIM_COEF_SHIFT));
  endproperty
  a_dual_imag: assert property (p_dual_imag) else $error("complex imag product wrong");

  property p_main_delay;
    @(posedge core_clk) disable iff (!nrst)
      cfg_age >= 4'ha |-> (dly[`DIM_HILB_DELAY] == $past(main_prod, 9));
  endproperty
  a_main_delay: assert property (p_main_delay) else $error("main delay not nine clocks");

  property p_hilb_off;
    @(posedge core_clk) disable iff (!nrst)
      !hilb_active |=> (dac_data == dim_sat($past(main_w)));
  endproperty
  a_hilb_off: assert property (p_hilb_off) else $error("hilbert off but output altered");

  property p_hilb_upper;
    @(posedge core_clk) disable iff (!nrst)
      hilb_active && !sideband |=> (dac_data == dim_sat($past(main_w) + $past(hilb_w)));
  endproperty
  a_hilb_upper: assert property (p_hilb_upper) else $error("hilbert sum wrong");

  property p_hilb_lower;
    @(posedge core_clk) disable iff (!nrst)
      hilb_active && sideband |=> (dac_data == dim_sat($past(main_w) - $past(hilb_w)));
  endproperty
  a_hilb_lower: assert property (p_hilb_lower) else $error("lower sideband sum wrong");

  property p_none_pass;
    @(posedge core_clk) disable iff (!nrst)
      s_settled ##0 (dual && !chsel && !ctrl[`DIM_F_HILB] && rate_code == `DIM_RATE_NONE)
      |-> (dac_data == $past(in_i, `DIM_LATENCY));
  endproperty
  a_none_pass: assert property (p_none_pass) else $error("unmodulated product altered");

endmodule : dim_if_modulator

// [dim_src.sv]
// stand-in for the two interpolation filter channels feeding the modulator
// assumes the bench calls put just after a rising edge of the dac update clock
`timescale 1ns/1ps

module dim_src
  import dim_pkg::*;
(
  output dim_sample_t in_i,
  output dim_sample_t in_q
);
  // ==================================================
  // sample stream
  // a sample is always present: the stream has no valid and never pauses
  initial begin
    in_i = '0;
    in_q = '0;
  end

  // one complex pair per clock, both halves change together
  task automatic put(input dim_sample_t i, input dim_sample_t q);
    in_i <= i;
    in_q <= q;
  endtask : put
endmodule : dim_src

// [tb_digital_if_modulator_hilbert.sv]
// self-checking bench for the digital if modulator
// assumes the design files and dim_src.sv are compiled first
`timescale 1ns/1ps

module tb_digital_if_modulator_hilbert
  import dim_pkg::*;
;
  logic core_clk;
  logic nrst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dim_sample_t in_i;
  dim_sample_t in_q;
  dim_sample_t dac_data;
  int fails;
  int num_checks;
  localparam int COS_T[8] = '{256, 181, 0, -181, -256, -181, 0, 181};
  localparam int HT[19] = '{-6, 0, -17, 0, -40, 0, -91, 0, -318, 0, 318, 0, 91, 0, 40, 0,
                            17, 0, 6};

  dim_if_modulator i_dim_if_modulator (
    .core_clk(core_clk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .in_i(in_i),
    .in_q(in_q),
    .dac_data(dac_data)
  );

  dim_src i_dim_src (
    .in_i(in_i),
    .in_q(in_q)
  );

  // ==================================================
  // clock, checking and bus helpers
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      fails++;
      $display("ERROR t=%0t bus wait got=%h exp=%h", $time, n, 1);
    end
    // an idle edge so the next request never lands in the same time step
    @(posedge core_clk);
  endtask : bus

  task automatic setc(input logic [5:0] v);
    logic [31:0] rd;
    bus(1'b1, 4'h0, {26'h0, v}, rd);
  endtask : setc

  function automatic int ep_of(input int r, input int p);
    case (r)
      1: return (p & 1) * 4;
      2: return (p & 3) * 2;
      3: return p & 7;
      default: return 0;
    endcase
  endfunction : ep_of

  function automatic int mixv(input int d, input int s, input int i, input int q, input int e);
    int c;
    int sn;
    c = COS_T[e];
    sn = COS_T[(e + 6) & 7];
    if (d == 0) begin
      return ((s != 0 ? q : i) * c) >>> 8;
    end
    return (s != 0) ? (i * sn + q * c) >>> 8 : (i * c - q * sn) >>> 8;
  endfunction : mixv

  // ==================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] rd;
    logic [31:0] r2;
    bus(1'b0, 4'h0, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 4'h4, 32'h0, rd);
    bus(1'b0, 4'h4, 32'h0, r2);
    check({27'h0, rd[8:4]}, 32'h1);
    check({28'h0, r2[3:0] - rd[3:0]}, 32'h3);
    setc(6'h3f);
    bus(1'b0, 4'h0, 32'h0, rd);
    check(rd, 32'h3f);
    bus(1'b1, 4'h8, 32'hffffffff, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    check(rd, 32'h0);
    setc(6'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pass();
    dim_sample_t hi[40];
    dim_sample_t hq[40];
    for (int s = 0; s < 2; s++) begin
      setc({4'h0, 1'(s), 1'b0});
      for (int n = 0; n < 40; n++) begin
        @(posedge core_clk);
        hi[n] = 16'(37 * n - 500);
        hq[n] = 16'(300 - 53 * n);
        i_dim_src.put(hi[n], hq[n]);
        #1;
        if (n >= 12) begin
          check({16'h0, dac_data}, {16'h0, (s != 0) ? hq[n-12] : hi[n-12]});
        end
      end
    end
    $display("test passthrough done");
  endtask : t_pass

  // constant input: the output must follow the carrier table at some phase offset
  task automatic t_mods();
    dim_sample_t got[16];
    logic ok;
    logic m;
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 2; s++) begin
        for (int r = 1; r < 4; r++) begin
          setc({2'b00, 2'(r), 1'(s), 1'(d)});
          i_dim_src.put(16'sd1000, -16'sd600);
          repeat (20) @(posedge core_clk);
          for (int n = 0; n < 16; n++) begin
            @(posedge core_clk);
            #1;
            got[n] = dac_data;
          end
          ok = 1'b0;
          for (int k = 0; k < 16; k++) begin
            m = 1'b1;
            for (int n = 0; n < 16; n++) begin
              if (got[n] !== 16'(mixv(d, s, 1000, -600, ep_of(r, (k + n) & 15)))) m = 1'b0;
            end
            if (m) ok = 1'b1;
          end
          check({31'h0, ok}, 32'h1);
        end
      end
    end
    $display("test modulation done");
  endtask : t_mods

  // impulse on both channels: main shows it at 12, the fir taps around it
  task automatic t_hilb();
    int main;
    int hv;
    int j;
    int e;
    for (int he = 0; he < 2; he++) begin
      for (int sb = 0; sb < 2; sb++) begin
        setc({1'(sb), 1'(he), 2'b00, 1'b0, 1'b1});
        i_dim_src.put(16'sd0, 16'sd0);
        repeat (24) @(posedge core_clk);
        i_dim_src.put(16'sd1024, 16'sd1024);
        for (int mm = 1; mm <= 24; mm++) begin
          @(posedge core_clk);
          if (mm == 1) i_dim_src.put(16'sd0, 16'sd0);
          #1;
          main = (mm == 12) ? 1024 : 0;
          j = mm - 3;
          hv = (he != 0 && j >= 0 && j < 19) ? (-1024 * HT[j]) >>> 9 : 0;
          e = (sb != 0) ? main - hv : main + hv;
          check({16'h0, dac_data}, {16'h0, 16'(e)});
        end
      end
    end
    $display("test hilbert done");
  endtask : t_hilb

  // ==================================================
  // run control
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    nrst = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_regs();
    t_pass();
    t_mods();
    t_hilb();
    print_verdict();
  end

  // the whole run needs about 800 clocks
  initial begin
    #50000;
    fails++;
    $display("ERROR t=%0t timeout got=%h exp=%h", $time, 0, 1);
    print_verdict();
  end
endmodule : tb_digital_if_modulator_hilbert
